// *** src/dtc_pkg.sv ***
// Constants shared by the dual timer/counter block
package dtc_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CONTROL_FLAGS = 8'h88;
    localparam logic [7:0] ADDR_MODE_CONFIG   = 8'h89;
    localparam logic [7:0] ADDR_ZERO_LOWER    = 8'h8a;
    localparam logic [7:0] ADDR_ONE_LOWER     = 8'h8b;
    localparam logic [7:0] ADDR_ZERO_UPPER    = 8'h8c;
    localparam logic [7:0] ADDR_ONE_UPPER     = 8'h8d;
    localparam logic [7:0] ADDR_CLOCK_CONFIG  = 8'h8e;
    localparam logic [7:0] ADDR_PIN_SETTING   = 8'hb5;
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'hf0;
    localparam logic [7:0] ADDR_IRQ_MASK      = 8'hf1;

    // Mode register layout, per channel stride of four bits
    localparam int CH_STRIDE      = 4;
    localparam int MODE_FIELD_LSB = 0;
    localparam int COUNTER_SEL    = 2;
    localparam int GATE_BIT       = 3;

    // Control flag layout
    localparam int RUN_ZERO_BIT   = 4;
    localparam int OVF_ZERO_BIT   = 5;
    localparam int RUN_ONE_BIT    = 6;
    localparam int OVF_ONE_BIT    = 7;

    // Clock config and pin setting layout
    localparam int CLK_MODE_ZERO  = 3;
    localparam int CLK_MODE_ONE   = 4;
    localparam int TOG_EN_ZERO    = 2;
    localparam int TOG_EN_ONE     = 3;
    localparam logic [7:0] PIN_SETTING_MASK = 8'h8d;

    // Mode field encodings
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    // Prescaler divides the system clock by twelve
    localparam logic [3:0] PRESC_LAST = 4'hb;
    localparam logic [3:0] PRESC_ZERO = 4'h0;
    localparam logic [3:0] PRESC_STEP = 4'h1;

    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [7:0]  BYTE_ONE   = 8'h01;
    localparam logic [7:0]  BYTE_FULL  = 8'hff;
    localparam logic [12:0] CNT13_ONE  = 13'h0001;
    localparam logic [15:0] CNT16_ONE  = 16'h0001;

endpackage

// *** src/dtc_timer_core.sv ***
// Two 16-bit timer/counters with overflow toggle outputs and byte registers
// Register map, one byte each
//   0x88 control flags: run and overflow bits
//   0x89 mode: gate, counter select, mode field
//   0x8a/0x8b lower count bytes, 0x8c/0x8d upper
//   0x8e clock config: direct clock per channel
//   0xb5 pin setting: toggle enables, storage bits
//   0xf0 interrupt status, write one to clear
//   0xf1 interrupt mask
//
// Count bytes are not latched as a pair; stop a
// channel before reading both bytes of it.
`timescale 1ns/100ps

module dtc_timer_core
    import dtc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    // Count pins, two-way
    input  wire logic       chan_zero_count_pin_in,
    output logic            chan_zero_count_pin_out,
    output logic            chan_zero_count_pin_oe,
    input  wire logic       chan_one_count_pin_in,
    output logic            chan_one_count_pin_out,
    output logic            chan_one_count_pin_oe,
    // Gate inputs
    input  wire logic       ext_irq_zero_pin,
    input  wire logic       ext_irq_one_pin,
    // Interrupt service handshake
    input  wire logic       chan_zero_irq_ack,
    input  wire logic       chan_one_irq_ack,
    output logic            chan_zero_overflow_flag,
    output logic            chan_one_overflow_flag,
    output logic            irq
);

    typedef struct packed {
        // Count bytes
        logic [1:0][7:0] count_lower;
        logic [1:0][7:0] count_upper;
        // Configuration
        logic [7:0]      mode_cfg;
        logic [1:0]      run;
        logic [1:0]      ovf;
        logic [1:0]      clk_mode;
        logic [7:0]      pin_setting;
        logic [1:0]      irq_stat;
        logic [1:0]      irq_mask;
        // Event state
        logic [3:0]      presc;
        logic [1:0]      pin_prev;
        logic [1:0]      tog;
        // Bus output
        logic [7:0]      rdata;
        logic            irq;
    } dtc_state_type;

    localparam dtc_state_type STATE_RESET = '{
        count_lower : '0,
        count_upper : '0,
        mode_cfg    : '0,
        run         : '0,
        ovf         : '0,
        clk_mode    : '0,
        pin_setting : '0,
        irq_stat    : '0,
        irq_mask    : '0,
        presc       : '0,
        pin_prev    : '0,
        tog         : 2'h3,
        rdata       : '0,
        irq         : 1'b0
    };

    dtc_state_type s_r;
    dtc_state_type s_nxt;

    logic [1:0] pin_in;
    logic [1:0] gate_pin;
    logic [1:0] ack;
    logic [1:0] tog_en;
    logic [1:0] timer_tick;
    logic [1:0] count_en;
    logic       pre_tick;

    assign pin_in   = {chan_one_count_pin_in, chan_zero_count_pin_in};
    assign gate_pin = {ext_irq_one_pin, ext_irq_zero_pin};
    assign ack      = {chan_one_irq_ack, chan_zero_irq_ack};
    assign tog_en   = {s_r.pin_setting[TOG_EN_ONE], s_r.pin_setting[TOG_EN_ZERO]};
    assign pre_tick = (s_r.presc == PRESC_LAST);

    // Per-channel tick source and gating
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            logic fall_edge;
            logic src_tick;
            logic gate_ok;
            // Pin counted only on a high sample followed by a low one
            assign fall_edge     = s_r.pin_prev[g] & ~pin_in[g];
            assign timer_tick[g] = s_r.clk_mode[g] | pre_tick;
            assign src_tick      = s_r.mode_cfg[g*CH_STRIDE + COUNTER_SEL] ?
                                   fall_edge : timer_tick[g];
            assign gate_ok       = ~s_r.mode_cfg[g*CH_STRIDE + GATE_BIT] | gate_pin[g];
            assign count_en[g]   = s_r.run[g] & gate_ok & src_tick;
        end
    endgenerate

    always_comb begin
        logic [1:0]  cnt_wr;
        logic [1:0]  ovf_ev;
        logic [1:0]  flag_set;
        logic        ovf_split;
        logic        split_zero;
        logic [1:0]  mode;
        logic [12:0] v13;
        logic [15:0] v16;
        logic [7:0]  timer_control_flags_rd;
        s_nxt      = s_r;
        cnt_wr     = '0;
        ovf_ev     = '0;
        flag_set   = '0;
        ovf_split  = 1'b0;
        mode       = '0;
        v13        = '0;
        v16        = '0;
        timer_control_flags_rd    = '0;
        split_zero = (s_r.mode_cfg[MODE_FIELD_LSB +: 2] == MODE_SPLIT);

        s_nxt.pin_prev = pin_in;
        // Prescaler runs free, so the first divided tick lands anywhere in twelve
        if (pre_tick) begin
            s_nxt.presc = PRESC_ZERO;
        end else begin
            s_nxt.presc = s_r.presc + PRESC_STEP;
        end

        // A byte write to a channel suppresses that channel's increment
        cnt_wr[0] = wr_en && (addr == ADDR_ZERO_LOWER || addr == ADDR_ZERO_UPPER);
        cnt_wr[1] = wr_en && (addr == ADDR_ONE_LOWER || addr == ADDR_ONE_UPPER);

        // Increment is skipped in a cycle that writes the same channel
        for (int i = 0; i < 2; i++) begin
            mode = s_r.mode_cfg[i*CH_STRIDE + MODE_FIELD_LSB +: 2];
            if (count_en[i] && !cnt_wr[i]) begin
                case (mode)
                    MODE_13BIT: begin
                        v13 = {s_r.count_upper[i], s_r.count_lower[i][4:0]};
                        ovf_ev[i] = &v13;
                        v13 = v13 + CNT13_ONE;
                        s_nxt.count_lower[i][4:0] = v13[4:0];
                        s_nxt.count_upper[i]      = v13[12:5];
                    end
                    MODE_16BIT: begin
                        v16 = {s_r.count_upper[i], s_r.count_lower[i]};
                        ovf_ev[i] = &v16;
                        v16 = v16 + CNT16_ONE;
                        s_nxt.count_lower[i] = v16[7:0];
                        s_nxt.count_upper[i] = v16[15:8];
                    end
                    MODE_RELOAD: begin
                        if (s_r.count_lower[i] == BYTE_FULL) begin
                            ovf_ev[i] = 1'b1;
                            s_nxt.count_lower[i] = s_r.count_upper[i];
                        end else begin
                            s_nxt.count_lower[i] = s_r.count_lower[i] + BYTE_ONE;
                        end
                    end
                    MODE_SPLIT: begin
                        // Channel one stands still in this mode
                        if (i == 0) begin
                            ovf_ev[i] = (s_r.count_lower[i] == BYTE_FULL);
                            s_nxt.count_lower[i] = s_r.count_lower[i] + BYTE_ONE;
                        end
                    end
                    default: begin
                        s_nxt.count_lower[i] = s_r.count_lower[i];
                    end
                endcase
            end
        end

        // Split mode: upper byte of channel zero runs on channel one's run bit
        if (split_zero && s_r.run[1] && timer_tick[0] && !cnt_wr[0]) begin
            ovf_split = (s_r.count_upper[0] == BYTE_FULL);
            s_nxt.count_upper[0] = s_r.count_upper[0] + BYTE_ONE;
        end

        // Split-mode upper byte reports as channel one
        flag_set[0] = ovf_ev[0];
        flag_set[1] = (ovf_ev[1] && !split_zero) || ovf_split;

        // Software byte writes override any increment
        if (wr_en) begin
            case (addr)
                ADDR_ZERO_LOWER: begin
                    s_nxt.count_lower[0] = wr_data;
                end
                ADDR_ZERO_UPPER: begin
                    s_nxt.count_upper[0] = wr_data;
                end
                ADDR_ONE_LOWER: begin
                    s_nxt.count_lower[1] = wr_data;
                end
                ADDR_ONE_UPPER: begin
                    s_nxt.count_upper[1] = wr_data;
                end
                ADDR_MODE_CONFIG: begin
                    s_nxt.mode_cfg = wr_data;
                end
                ADDR_CLOCK_CONFIG: begin
                    s_nxt.clk_mode = {wr_data[CLK_MODE_ONE], wr_data[CLK_MODE_ZERO]};
                end
                ADDR_PIN_SETTING: begin
                    s_nxt.pin_setting = wr_data & PIN_SETTING_MASK;
                end
                ADDR_CONTROL_FLAGS: begin
                    s_nxt.run = {wr_data[RUN_ONE_BIT], wr_data[RUN_ZERO_BIT]};
                    s_nxt.ovf = {wr_data[OVF_ONE_BIT], wr_data[OVF_ZERO_BIT]};
                end
                ADDR_IRQ_STATUS: begin
                    // Write one to clear; a same-cycle event still wins below
                    s_nxt.irq_stat = s_r.irq_stat & ~wr_data[1:0];
                end
                ADDR_IRQ_MASK: begin
                    s_nxt.irq_mask = wr_data[1:0];
                end
                default: begin
                    s_nxt.irq_mask = s_r.irq_mask;
                end
            endcase
        end

        // Service clears the flag, but a coinciding overflow still wins
        s_nxt.ovf      = (s_nxt.ovf & ~ack) | flag_set;
        s_nxt.irq_stat = s_nxt.irq_stat | flag_set;

        // Toggle register rests at one whenever toggling is disabled
        for (int i = 0; i < 2; i++) begin
            if (!tog_en[i]) begin
                s_nxt.tog[i] = 1'b1;
            end else if (flag_set[i]) begin
                s_nxt.tog[i] = ~s_r.tog[i];
            end
        end

        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

        // Read data stand for the single cycle after the strobe
        // Control flag byte carries only run and overflow bits
        timer_control_flags_rd = BYTE_ZERO;
        timer_control_flags_rd[OVF_ONE_BIT]  = s_r.ovf[1];
        timer_control_flags_rd[RUN_ONE_BIT]  = s_r.run[1];
        timer_control_flags_rd[OVF_ZERO_BIT] = s_r.ovf[0];
        timer_control_flags_rd[RUN_ZERO_BIT] = s_r.run[0];
        s_nxt.rdata = BYTE_ZERO;
        if (rd_en) begin
            case (addr)
                ADDR_CONTROL_FLAGS: begin
                    s_nxt.rdata = timer_control_flags_rd;
                end
                ADDR_MODE_CONFIG: begin
                    s_nxt.rdata = s_r.mode_cfg;
                end
                ADDR_ZERO_LOWER: begin
                    s_nxt.rdata = s_r.count_lower[0];
                end
                ADDR_ONE_LOWER: begin
                    s_nxt.rdata = s_r.count_lower[1];
                end
                ADDR_ZERO_UPPER: begin
                    s_nxt.rdata = s_r.count_upper[0];
                end
                ADDR_ONE_UPPER: begin
                    s_nxt.rdata = s_r.count_upper[1];
                end
                ADDR_CLOCK_CONFIG: begin
                    s_nxt.rdata[CLK_MODE_ONE]  = s_r.clk_mode[1];
                    s_nxt.rdata[CLK_MODE_ZERO] = s_r.clk_mode[0];
                end
                ADDR_PIN_SETTING: begin
                    s_nxt.rdata = s_r.pin_setting;
                end
                ADDR_IRQ_STATUS: begin
                    s_nxt.rdata = {6'h00, s_r.irq_stat};
                end
                ADDR_IRQ_MASK: begin
                    s_nxt.rdata = {6'h00, s_r.irq_mask};
                end
                default: begin
                    s_nxt.rdata = BYTE_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= STATE_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Toggle output shares the count pin; enable comes from the setting flop
    assign chan_zero_count_pin_out = s_r.tog[0];
    assign chan_zero_count_pin_oe  = s_r.pin_setting[TOG_EN_ZERO];
    assign chan_one_count_pin_out  = s_r.tog[1];
    assign chan_one_count_pin_oe   = s_r.pin_setting[TOG_EN_ONE];

    // Flags, interrupt and read data straight from the state register
    assign chan_zero_overflow_flag = s_r.ovf[0];
    assign chan_one_overflow_flag  = s_r.ovf[1];
    assign irq                     = s_r.irq;
    assign rd_data                 = s_r.rdata;

endmodule

// *** sim/dtc_pin_src.sv ***
// Far-side pulse source for the two count pins
`timescale 1ns/100ps

module dtc_pin_src (
    // Clock
    input  wire logic       mclk,
    // Pulse enable per pin
    input  wire logic [1:0] go,
    // Core pin drive
    input  wire logic [1:0] oe,
    input  wire logic [1:0] dout,
    // Resolved pin levels
    output logic      [1:0] pin
);
    logic [1:0] ph0 = 2'h0;
    logic [1:0] ph1 = 2'h0;

    // Two cycles high, two low, so each fall is sampled once
    always @(posedge mclk) begin
        ph0 <= go[0] ? ph0 + 2'h1 : 2'h0;
        ph1 <= go[1] ? ph1 + 2'h1 : 2'h0;
    end

    // Core owns the pin while toggling
    assign pin = (oe & dout) | (~oe & ~{ph1[1], ph0[1]});
endmodule

// *** sim/dtc_timer_core_props.sv ***
// Port assertions for the dual timer/counter core
`timescale 1ns/100ps

module dtc_timer_core_props
    import dtc_pkg::*;
(
    // Clock, reset
    input wire logic       mclk,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rd_data,
    // Pins and flags
    input wire logic       chan_zero_count_pin_out,
    input wire logic       chan_zero_count_pin_oe,
    input wire logic       chan_zero_overflow_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] a); rd_en && addr == a; endsequence
    sequence s_wr(logic [7:0] a, int b); wr_en && addr == a && wr_data[b]; endsequence
    property p_rd_idle; !rd_en |=> rd_data == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_hold; !chan_zero_count_pin_oe |-> chan_zero_count_pin_out; endproperty
    a_hold: assert property (p_hold) else $error("pin low while toggle off");
    property p_first; $rose(chan_zero_count_pin_oe) |-> chan_zero_count_pin_out; endproperty
    a_first: assert property (p_first) else $error("toggle did not start high");
    property p_flip; chan_zero_count_pin_oe && $past(chan_zero_count_pin_oe)
        && $changed(chan_zero_count_pin_out) |-> chan_zero_overflow_flag; endproperty
    a_flip: assert property (p_flip) else $error("toggle without overflow");
    property p_rd_flag; s_rd(ADDR_CONTROL_FLAGS)
        |=> rd_data[5] == $past(chan_zero_overflow_flag) && rd_data[3:0] == 4'h0; endproperty
    a_rd_flag: assert property (p_rd_flag) else $error("flag read wrong");
    property p_rd_pin; s_rd(ADDR_PIN_SETTING)
        |=> rd_data[2] == $past(chan_zero_count_pin_oe); endproperty
    a_rd_pin: assert property (p_rd_pin) else $error("pin setting read wrong");
    property p_oe_on; s_wr(ADDR_PIN_SETTING, TOG_EN_ZERO) |=> chan_zero_count_pin_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("pin not driven");
    property p_sw_set; s_wr(ADDR_CONTROL_FLAGS, OVF_ZERO_BIT) |=> chan_zero_overflow_flag;
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("flag not set by write");
endmodule

bind dtc_timer_core dtc_timer_core_props u_props (
    .mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .chan_zero_count_pin_out(chan_zero_count_pin_out),
    .chan_zero_count_pin_oe(chan_zero_count_pin_oe),
    .chan_zero_overflow_flag(chan_zero_overflow_flag)
);

// *** sim/tb_dtc_timer_core.sv ***
// Self-checking bench for the dual timer/counter core
`timescale 1ns/100ps

module tb_dtc_timer_core;
    import dtc_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        irq;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wr_data = 8'h00;
    logic [7:0]  rd_data;
    logic [7:0]  v;
    logic [1:0]  go = 2'h0;
    logic [1:0]  ack = 2'h0;
    logic [1:0]  gate = 2'h3;
    logic [1:0]  oe;
    logic [1:0]  dout;
    logic [1:0]  pin;
    logic [1:0]  ovf;
    logic [31:0] rs = 32'h0000_005c;
    int          fail_count = 0;
    int          num_checks = 0;
    int          n;

    always #4 mclk = ~mclk;

    dtc_timer_core uut (
        .mclk(mclk), .rst(rst), .ce(1'b1), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .chan_zero_count_pin_in(pin[0]), .chan_zero_count_pin_out(dout[0]),
        .chan_zero_count_pin_oe(oe[0]), .chan_one_count_pin_in(pin[1]),
        .chan_one_count_pin_out(dout[1]), .chan_one_count_pin_oe(oe[1]),
        .ext_irq_zero_pin(gate[0]), .ext_irq_one_pin(gate[1]),
        .chan_zero_irq_ack(ack[0]), .chan_one_irq_ack(ack[1]),
        .chan_zero_overflow_flag(ovf[0]), .chan_one_overflow_flag(ovf[1]), .irq(irq)
    );
    dtc_pin_src src (.mclk(mclk), .go(go), .oe(oe), .dout(dout), .pin(pin));

    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    // Stop before reading so the byte pair is coherent
    task automatic run_n(logic [7:0] r, int k);
        wr(ADDR_CONTROL_FLAGS, r);
        repeat (k) @(posedge mclk);
        wr(ADDR_CONTROL_FLAGS, 8'h00);
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(i < 7 ? 8'(8'h88 + i) : (i == 7 ? ADDR_PIN_SETTING : 8'h00));
            check(v, 8'h00);
        end
        check(8'({oe, dout, ovf}), 8'h0c);
        wr(ADDR_CLOCK_CONFIG, 8'h18);
        wr(ADDR_MODE_CONFIG, 8'h11);
        for (int c = 0; c < 2; c++) begin
            rs = xs(rs);
            n = int'(rs[4:0]) + 1;
            run_n(c ? 8'h40 : 8'h10, n);
            repeat (4) @(posedge mclk);
            rd(c ? ADDR_ONE_LOWER : ADDR_ZERO_LOWER);
            check(v, 8'(n + 2));
        end
        // Channel one on the divided clock: phase of the divider is free
        wr(ADDR_CLOCK_CONFIG, 8'h08);
        wr(ADDR_ONE_LOWER, 8'h00);
        n = int'(rs[9:8]) + 1;
        run_n(8'h40, 12 * n);
        rd(ADDR_ONE_LOWER);
        check(8'(v == 8'(n) || v == 8'(n + 1)), 8'h01);
        wr(ADDR_MODE_CONFIG, 8'h19);
        for (int g = 0; g < 2; g++) begin
            wr(ADDR_ZERO_LOWER, 8'h00);
            gate <= {1'b1, g[0]};
            run_n(8'h10, n);
            rd(ADDR_ZERO_LOWER);
            check(v, g ? 8'(n + 2) : 8'h00);
        end
        wr(ADDR_MODE_CONFIG, 8'h55);
        wr(ADDR_ZERO_LOWER, 8'h00);
        wr(ADDR_ONE_LOWER, 8'h00);
        wr(ADDR_CONTROL_FLAGS, 8'h50);
        go <= 2'h3;
        repeat (4 * n) @(posedge mclk);
        go <= 2'h0;
        run_n(8'h00, 2);
        rd(ADDR_ZERO_LOWER);
        check(v, 8'(n));
        rd(ADDR_ONE_LOWER);
        check(v, 8'(n));
        wr(ADDR_MODE_CONFIG, 8'h11);
        wr(ADDR_CONTROL_FLAGS, 8'h10);
        rs = xs(rs);
        wr(ADDR_ZERO_LOWER, rs[7:0]);
        rd(ADDR_ZERO_LOWER);
        check(v, rs[7:0] + 8'h01);
        // Timer source while toggling
        wr(ADDR_MODE_CONFIG, 8'h12);
        wr(ADDR_ZERO_UPPER, 8'hfc);
        wr(ADDR_ZERO_LOWER, 8'hfc);
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_PIN_SETTING, 8'h04);
        #1 check(8'({oe[0], dout[0]}), 8'h03);
        wr(ADDR_CONTROL_FLAGS, 8'h10);
        #1;
        for (n = 0; n < 20 && ovf[0] !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        if (n == 20) begin
            fail_count++;
            finish_test;
        end
        check(8'({dout[0], irq}), 8'h01);
        repeat (4) @(posedge mclk);
        #1 check(8'(dout[0]), 8'h01);
        wr(ADDR_CONTROL_FLAGS, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h00);
        #1 check(8'(irq), 8'h00);
        wr(ADDR_IRQ_MASK, 8'h01);
        #1 check(8'(irq), 8'h01);
        wr(ADDR_IRQ_STATUS, 8'h01);
        #1 check(8'(irq), 8'h00);
        wr(ADDR_CONTROL_FLAGS, 8'h20);
        @(posedge mclk);
        ack <= 2'h1;
        @(posedge mclk);
        ack <= 2'h0;
        #1 check(8'(ovf[0]), 8'h00);
        finish_test;
    end
endmodule
